// file: design/mib_pkg.sv
// Shared constants and types for the transfer, bit and control execution unit.
// Assumes a 32-bit APB bus with byte addresses and a single 100 MHz clock.
package mib_pkg;

  // APB address width and register byte offsets
  localparam int APB_AW = 12;
  localparam logic [APB_AW-1:0] OFF_CMD = 12'h000;
  localparam logic [APB_AW-1:0] OFF_KWORD = 12'h004;
  localparam logic [APB_AW-1:0] OFF_STATUS = 12'h008;
  localparam logic [APB_AW-1:0] OFF_STATUS_REGISTER = 12'h00C;
  localparam logic [APB_AW-1:0] OFF_SP = 12'h010;
  localparam logic [APB_AW-1:0] OFF_SLEEPCFG = 12'h014;
  localparam logic [APB_AW-1:0] OFF_CYCLES = 12'h018;
  localparam logic [APB_AW-1:0] OFF_GPR_BASE = 12'h080;

  // Status register bit positions
  localparam int SR_C = 0;
  localparam int SR_Z = 1;
  localparam int SR_N = 2;
  localparam int SR_V = 3;
  localparam int SR_T = 6;
  localparam int SR_I = 7;

  // Status word field positions
  localparam int ST_BUSY = 8;
  localparam int ST_HALT = 9;
  localparam int ST_PWAIT = 10;

  // Values after reset
  localparam logic [7:0] STATUS_REGISTER_RST = 8'h00;
  localparam logic [15:0] SP_RST = 16'h00FF;
  localparam logic [2:0] SLEEP_RST = 3'h0;

  // Cycles taken by each class of instruction
  localparam logic [7:0] CYC_ONE = 8'h01;
  localparam logic [7:0] CYC_MEM = 8'h02;
  localparam logic [7:0] CYC_PROG = 8'h03;

  // Operations, numbered densely from zero
  typedef enum logic [5:0] {
    OP_NOP = 6'h00, OP_ST_Z_INC, OP_ST_Z_DEC, OP_ST_Z_DISP, OP_STORE_DIRECT_DATA,
    OP_LOAD_PROGRAM_MEMORY_R0, OP_LOAD_PROGRAM_MEMORY, OP_LOAD_PROGRAM_MEMORY_INC,
    OP_STORE_PROGRAM_MEMORY, OP_PUSH, OP_POP, OP_SET_IO_BIT, OP_CLEAR_IO_BIT,
    OP_LOGICAL_SHIFT_UP, OP_LOGICAL_SHIFT_DOWN, OP_ROTATE_UP_THROUGH_CARRY,
    OP_ROTATE_DOWN_THROUGH_CARRY, OP_ARITH_SHIFT_DOWN, OP_BIT_TO_TRANSFER_FLAG,
    OP_TRANSFER_FLAG_TO_BIT, OP_FLAG_SET, OP_FLAG_CLEAR, OP_GLOBAL_IRQ_ON,
    OP_GLOBAL_IRQ_OFF, OP_SLEEP, OP_WATCHDOG_RESTART, OP_BREAK
  } mib_op_e;

  // Sequencer states, Gray coded along the usual path
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000, ST_EX1 = 3'b001, ST_EX2 = 3'b011, ST_EX3 = 3'b010,
    ST_PWAIT_S = 3'b110, ST_HALT_S = 3'b100
  } mib_state_e;

  // Command word as written over APB (low 20 bits)
  typedef struct packed {
    logic [5:0] disp;
    logic [2:0] bitsel;
    logic [4:0] rsel;
    mib_op_e op;
  } mib_cmd_s;

  localparam mib_cmd_s CMD_RST = '{disp: 6'h00, bitsel: 3'h0, rsel: 5'h00, op: OP_NOP};

  // Memory and I/O request carriers
  typedef struct packed {
    logic req;
    logic we;
    logic [15:0] addr;
    logic [7:0] wdata;
  } mib_dmem_s;

  typedef struct packed {
    logic req;
    logic we;
    logic [15:0] addr;
    logic [15:0] wdata;
  } mib_pmem_s;

  typedef struct packed {
    logic req;
    logic [5:0] addr;
    logic [7:0] mask;
    logic [7:0] wdata;
  } mib_io_s;

endpackage

// file: design/mib_exec_unit.sv
// Execution unit for stores, program-memory access, stack, bit and control operations.
// Assumes data memory answers reads in the strobe cycle, program memory one cycle later.
//
// Summary of operation
// - Store via Z post-increment writes register, then Z plus one, 2 cycles.
// - Store via Z pre-decrement decrements Z, then writes new location, 2 cycles.
// - Displaced store writes to Z plus displacement, Z unchanged, 2 cycles.
// - Direct store writes register to given address, 2 cycles, no flags.
// - Program load fetches byte at Z to R0 or register; optional increment; 3 cycles.
// - Program store writes R1:R0 at Z; length set by memory ready.
// - Push stores register on stack, pop loads it; 2 cycles, no flags.
// - I/O bit set or clear forces one bit of I/O register, 2 cycles.
// - Logical shift up inserts zero at bit 0; updates Z,C,N,V in 1 cycle.
// - Logical shift down inserts zero at bit 7; updates Z,C,N,V in 1 cycle.
// - Rotate up: old carry into bit 0, bit 7 into carry; 1 cycle.
// - Rotate down: old carry into bit 7, bit 0 into carry; 1 cycle.
// - Arithmetic shift down keeps bit 7; updates Z,C,N,V in 1 cycle.
// - Bit to transfer flag copies one register bit into T only, 1 cycle.
// - Transfer flag to bit copies T into register bit, no flags, 1 cycle.
// - Flag set and clear touch only their own status bit, 1 cycle.
// - Global interrupt on and off set or clear enable bit, 1 cycle.
// - Sleep takes 1 cycle, no flags, enters configured low-power mode.
// - Watchdog restart takes 1 cycle, no flags, restarts watchdog count.
// - Break serves debugging only, no fixed length, no flag change.
`timescale 1ns/1ps
module mib_exec_unit
  import mib_pkg::*;
#(
  parameter int NUM_GPR = 32
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [APB_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Data memory
  output mib_dmem_s dmem,
  input wire logic [7:0] dmem_rdata,
  // Program memory
  output mib_pmem_s pmem,
  input wire logic [7:0] pmem_rdata,
  input wire logic pmem_ready,
  // I/O space
  output mib_io_s io,
  // MCU control
  output logic sleep_enter,
  output logic [2:0] sleep_mode,
  output logic wdt_restart,
  output logic debug_break,
  output logic global_irq_en,
  input wire logic debug_resume
);

  // Pointer Z lives in the top two registers, so the file size is fixed
  if (NUM_GPR != 32) begin : g_bad_gpr
    $error("NUM_GPR must be 32");
  end

  mib_state_e state_q;
  mib_cmd_s cmd_q;
  logic [15:0] kword_q;
  logic [7:0] status_register_q;
  logic [15:0] sp_q;
  logic [7:0] cyc_q;
  logic [7:0] last_cyc_q;
  logic [7:0] rf [0:NUM_GPR-1];

  // Shift and rotate result with carry out in bit 8
  function automatic logic [8:0] shift_calc(input mib_op_e op, input logic [7:0] v,
                                            input logic c);
    unique case (op)
      OP_LOGICAL_SHIFT_UP: shift_calc = {v[7], v[6:0], 1'b0};
      OP_LOGICAL_SHIFT_DOWN: shift_calc = {v[0], 1'b0, v[7:1]};
      OP_ROTATE_UP_THROUGH_CARRY: shift_calc = {v[7], v[6:0], c};
      OP_ROTATE_DOWN_THROUGH_CARRY: shift_calc = {v[0], c, v[7:1]};
      OP_ARITH_SHIFT_DOWN: shift_calc = {v[0], v[7], v[7:1]};
      default: shift_calc = {c, v};
    endcase
  endfunction

  // Operation class decode
  function automatic logic is_shift(input mib_op_e op);
    is_shift = op inside {OP_LOGICAL_SHIFT_UP, OP_LOGICAL_SHIFT_DOWN,
                          OP_ROTATE_UP_THROUGH_CARRY, OP_ROTATE_DOWN_THROUGH_CARRY,
                          OP_ARITH_SHIFT_DOWN};
  endfunction

  // APB decode
  wire busy = state_q != ST_IDLE;
  wire apb_acc = psel & penable & ~pready;
  wire apb_fire = psel & penable & pready;
  wire wr_ok = apb_fire & pwrite & ~pslverr;
  wire aligned = paddr[1:0] == 2'b00;
  wire hit_cmd = aligned & (paddr == OFF_CMD);
  wire hit_kword = aligned & (paddr == OFF_KWORD);
  wire hit_status = aligned & (paddr == OFF_STATUS);
  wire hit_status_register = aligned & (paddr == OFF_STATUS_REGISTER);
  wire hit_sp = aligned & (paddr == OFF_SP);
  wire hit_sleep = aligned & (paddr == OFF_SLEEPCFG);
  wire hit_cycles = aligned & (paddr == OFF_CYCLES);
  wire hit_gpr = aligned & (paddr[APB_AW-1:7] == OFF_GPR_BASE[APB_AW-1:7]);
  wire [4:0] gpr_idx = paddr[6:2];
  wire mapped = hit_cmd | hit_kword | hit_status | hit_status_register | hit_sp | hit_sleep
              | hit_cycles | hit_gpr;
  // Core state must not move under a running instruction
  wire locked = busy & pwrite & (hit_cmd | hit_kword | hit_status_register | hit_sp | hit_gpr);
  wire bad_op = pwrite & hit_cmd & (pwdata[5:0] > OP_BREAK);
  wire apb_bad = ~mapped | locked | bad_op;
  wire start = wr_ok & hit_cmd;

  // Read data selection
  wire [31:0] status_word = {21'h0, state_q == ST_PWAIT_S, state_q == ST_HALT_S, busy, status_register_q};
  wire [31:0] rd_mux = hit_cmd ? {12'h0, cmd_q} :
                       hit_kword ? {16'h0, kword_q} :
                       hit_status ? status_word :
                       hit_status_register ? {24'h0, status_register_q} :
                       hit_sp ? {16'h0, sp_q} :
                       hit_sleep ? {29'h0, sleep_mode} :
                       hit_cycles ? {24'h0, last_cyc_q} :
                       hit_gpr ? {24'h0, rf[gpr_idx]} : 32'h0;

  // One wait state per transfer keeps pready and prdata registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= apb_acc;
      pslverr <= apb_acc & apb_bad;
      prdata <= (apb_acc & ~pwrite & ~apb_bad) ? rd_mux : 32'h0000_0000;
    end
  end

  // Operand and address computation
  wire [15:0] zptr = {rf[31], rf[30]};
  wire [7:0] rsrc = rf[cmd_q.rsel];
  wire [15:0] z_inc = zptr + 16'h0001;
  wire [15:0] z_dec = zptr - 16'h0001;
  wire [15:0] z_disp = zptr + {10'h000, cmd_q.disp};
  wire [7:0] bit_mask = 8'h01 << cmd_q.bitsel;
  wire [8:0] sh = shift_calc(cmd_q.op, rsrc, status_register_q[SR_C]);
  wire sh_n = sh[7];
  wire in_ex1 = state_q == ST_EX1;
  wire in_ex2 = state_q == ST_EX2;
  wire in_ex3 = state_q == ST_EX3;
  wire op_store = cmd_q.op inside {OP_ST_Z_INC, OP_ST_Z_DEC, OP_ST_Z_DISP,
                                   OP_STORE_DIRECT_DATA, OP_PUSH};
  wire op_lpm = cmd_q.op inside {OP_LOAD_PROGRAM_MEMORY_R0, OP_LOAD_PROGRAM_MEMORY,
                                 OP_LOAD_PROGRAM_MEMORY_INC};
  wire op_two = op_store | (cmd_q.op inside {OP_POP, OP_SET_IO_BIT, OP_CLEAR_IO_BIT});
  wire op_one = ~op_two & ~op_lpm & (cmd_q.op != OP_STORE_PROGRAM_MEMORY)
              & (cmd_q.op != OP_BREAK);

  wire [15:0] st_addr = (cmd_q.op == OP_ST_Z_INC) ? zptr :
                        (cmd_q.op == OP_ST_Z_DEC) ? z_dec :
                        (cmd_q.op == OP_ST_Z_DISP) ? z_disp :
                        (cmd_q.op == OP_PUSH) ? sp_q : kword_q;

  // Instruction end and next state
  wire finish = (in_ex1 & op_one) | (in_ex2 & ~op_lpm) | in_ex3
              | ((state_q == ST_PWAIT_S) & pmem_ready)
              | ((state_q == ST_HALT_S) & debug_resume);
  wire [7:0] cyc_inc = (cyc_q == 8'hFF) ? cyc_q : cyc_q + 8'h01;
  mib_state_e next_state;
  always_comb begin
    next_state = state_q;
    unique case (state_q)
      ST_IDLE: if (start) next_state = ST_EX1;
      ST_EX1: begin
        if (op_two | op_lpm) next_state = ST_EX2;
        else if (cmd_q.op == OP_STORE_PROGRAM_MEMORY) next_state = ST_PWAIT_S;
        else if (cmd_q.op == OP_BREAK) next_state = ST_HALT_S;
        else next_state = ST_IDLE;
      end
      ST_EX2: next_state = op_lpm ? ST_EX3 : ST_IDLE;
      ST_EX3: next_state = ST_IDLE;
      ST_PWAIT_S: if (pmem_ready) next_state = ST_IDLE;
      ST_HALT_S: if (debug_resume) next_state = ST_IDLE;
      default: next_state = ST_IDLE;
    endcase
  end

  // Sequencer, command latch and cycle accounting
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_IDLE;
      cmd_q <= CMD_RST;
      kword_q <= 16'h0000;
      cyc_q <= 8'h00;
      last_cyc_q <= 8'h00;
      sleep_mode <= SLEEP_RST;
    end else begin
      state_q <= next_state;
      if (start) cmd_q <= mib_cmd_s'(pwdata[19:0]);
      if (wr_ok & hit_kword) kword_q <= pwdata[15:0];
      if (wr_ok & hit_sleep) sleep_mode <= pwdata[2:0];
      cyc_q <= start ? CYC_ONE : cyc_inc;
      if (finish) last_cyc_q <= cyc_q;
    end
  end

  // Memory and I/O strobes: set in the first cycle, visible in the second
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dmem <= '0;
      pmem <= '0;
      io <= '0;
    end else begin
      dmem.req <= 1'b0;
      io.req <= 1'b0;
      pmem.req <= (state_q == ST_PWAIT_S) & ~pmem_ready;
      if (in_ex1 & op_store) begin
        dmem <= '{req: 1'b1, we: 1'b1, addr: st_addr, wdata: rsrc};
      end
      if (in_ex1 & (cmd_q.op == OP_POP)) begin
        dmem <= '{req: 1'b1, we: 1'b0, addr: sp_q + 16'h0001, wdata: 8'h00};
      end
      if (in_ex1 & (cmd_q.op inside {OP_SET_IO_BIT, OP_CLEAR_IO_BIT})) begin
        io <= '{req: 1'b1, addr: cmd_q.disp, mask: bit_mask,
                wdata: (cmd_q.op == OP_SET_IO_BIT) ? 8'hFF : 8'h00};
      end
      if (in_ex1 & op_lpm) begin
        pmem <= '{req: 1'b1, we: 1'b0, addr: zptr, wdata: 16'h0000};
      end
      if (in_ex1 & (cmd_q.op == OP_STORE_PROGRAM_MEMORY)) begin
        pmem <= '{req: 1'b1, we: 1'b1, addr: zptr, wdata: {rf[1], rf[0]}};
      end
    end
  end

  // MCU control pulses
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sleep_enter <= 1'b0;
      wdt_restart <= 1'b0;
      debug_break <= 1'b0;
    end else begin
      sleep_enter <= in_ex1 & (cmd_q.op == OP_SLEEP);
      wdt_restart <= in_ex1 & (cmd_q.op == OP_WATCHDOG_RESTART);
      debug_break <= in_ex1 & (cmd_q.op == OP_BREAK);
    end
  end

  // Register file write port select
  wire apb_gpr_we = wr_ok & hit_gpr;
  wire lpm_we = in_ex3;
  wire [4:0] lpm_dst = (cmd_q.op == OP_LOAD_PROGRAM_MEMORY_R0) ? 5'd0 : cmd_q.rsel;
  wire z_we = in_ex1 & (cmd_q.op inside {OP_ST_Z_INC, OP_ST_Z_DEC})
            | in_ex3 & (cmd_q.op == OP_LOAD_PROGRAM_MEMORY_INC);
  wire [15:0] z_next = (cmd_q.op == OP_ST_Z_DEC) ? z_dec : z_inc;

  // Register file; Z update is last so it wins over a clash
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NUM_GPR; i++) rf[i] <= 8'h00;
    end else begin
      if (apb_gpr_we) rf[gpr_idx] <= pwdata[7:0];
      if (in_ex1 & is_shift(cmd_q.op)) rf[cmd_q.rsel] <= sh[7:0];
      if (in_ex1 & (cmd_q.op == OP_TRANSFER_FLAG_TO_BIT)) begin
        rf[cmd_q.rsel][cmd_q.bitsel] <= status_register_q[SR_T];
      end
      if (in_ex2 & (cmd_q.op == OP_POP)) rf[cmd_q.rsel] <= dmem_rdata;
      if (lpm_we) rf[lpm_dst] <= pmem_rdata;
      if (z_we) begin
        rf[30] <= z_next[7:0];
        rf[31] <= z_next[15:8];
      end
    end
  end

  // Status register and stack pointer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_register_q <= STATUS_REGISTER_RST;
      sp_q <= SP_RST;
    end else begin
      if (wr_ok & hit_status_register) status_register_q <= pwdata[7:0];
      if (wr_ok & hit_sp) sp_q <= pwdata[15:0];
      if (in_ex1) begin
        unique case (cmd_q.op)
          OP_LOGICAL_SHIFT_UP, OP_LOGICAL_SHIFT_DOWN, OP_ROTATE_UP_THROUGH_CARRY,
          OP_ROTATE_DOWN_THROUGH_CARRY, OP_ARITH_SHIFT_DOWN: begin
            status_register_q[SR_C] <= sh[8];
            status_register_q[SR_Z] <= sh[7:0] == 8'h00;
            status_register_q[SR_N] <= sh_n;
            status_register_q[SR_V] <= sh_n ^ sh[8];
          end
          OP_BIT_TO_TRANSFER_FLAG: status_register_q[SR_T] <= rsrc[cmd_q.bitsel];
          OP_FLAG_SET: status_register_q[cmd_q.bitsel] <= 1'b1;
          OP_FLAG_CLEAR: status_register_q[cmd_q.bitsel] <= 1'b0;
          OP_GLOBAL_IRQ_ON: status_register_q[SR_I] <= 1'b1;
          OP_GLOBAL_IRQ_OFF: status_register_q[SR_I] <= 1'b0;
          OP_PUSH: sp_q <= sp_q - 16'h0001;
          OP_POP: sp_q <= sp_q + 16'h0001;
          default: status_register_q <= status_register_q;
        endcase
      end
    end
  end

  // Interrupt enable drives straight from its status flop
  assign global_irq_en = status_register_q[SR_I];

  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_write_then_idle;
    (dmem.req && dmem.we) ##1 (state_q == ST_IDLE && !dmem.req);
  endsequence

  sequence s_prog_read;
    (state_q == ST_EX2 && pmem.req && !pmem.we) ##1 (state_q == ST_EX3) ##1 (state_q == ST_IDLE);
  endsequence

  a_post_inc_ptr: assert property (in_ex1 && cmd_q.op == OP_ST_Z_INC |=>
    (dmem.addr == $past(zptr) && zptr == $past(zptr) + 16'h0001) and s_write_then_idle)
    else $error("post-increment store wrong");

  a_pre_dec_addr: assert property (in_ex1 && cmd_q.op == OP_ST_Z_DEC |=>
    (dmem.addr == $past(zptr) - 16'h0001 && zptr == dmem.addr) and s_write_then_idle)
    else $error("pre-decrement store wrong");

  a_disp_store: assert property (in_ex1 && cmd_q.op == OP_ST_Z_DISP |=>
    (dmem.addr == $past(z_disp) && $stable(zptr)) and s_write_then_idle)
    else $error("displaced store wrong");

  a_direct_store: assert property (in_ex1 && cmd_q.op == OP_STORE_DIRECT_DATA |=>
    dmem.addr == kword_q && dmem.wdata == $past(rsrc) && $stable(status_register_q) ##1 state_q == ST_IDLE)
    else $error("direct store wrong");

  a_prog_load_len: assert property (in_ex1 && op_lpm |=> s_prog_read)
    else $error("program load not three cycles");

  a_prog_store_pair: assert property (in_ex1 && cmd_q.op == OP_STORE_PROGRAM_MEMORY |=>
    pmem.we && pmem.wdata == {rf[1], rf[0]} && pmem.addr == zptr)
    else $error("program store data wrong");

  a_push_stack: assert property (in_ex1 && cmd_q.op == OP_PUSH |=>
    sp_q == $past(sp_q) - 16'h0001 && dmem.addr == $past(sp_q) && $stable(status_register_q))
    else $error("push wrong");

  a_io_bit_mask: assert property (in_ex1 && cmd_q.op == OP_SET_IO_BIT |=>
    io.req && io.mask == (8'h01 << $past(cmd_q.bitsel)) && io.wdata == 8'hFF ##1 !io.req)
    else $error("I/O bit set wrong");

  a_shift_up_flags: assert property (in_ex1 && cmd_q.op == OP_LOGICAL_SHIFT_UP |=>
    rf[$past(cmd_q.rsel)] == {$past(rsrc[6:0]), 1'b0} && status_register_q[SR_C] == $past(rsrc[7])
    && state_q == ST_IDLE)
    else $error("shift up wrong");

  a_rotate_down: assert property (in_ex1 && cmd_q.op == OP_ROTATE_DOWN_THROUGH_CARRY |=>
    rf[$past(cmd_q.rsel)] == {$past(status_register_q[SR_C]), $past(rsrc[7:1])}
    && status_register_q[SR_C] == $past(rsrc[0]))
    else $error("rotate down wrong");

  a_flag_only: assert property (in_ex1 && cmd_q.op == OP_FLAG_SET |=>
    status_register_q == ($past(status_register_q) | (8'h01 << $past(cmd_q.bitsel))))
    else $error("flag set touched other flags");

  a_wdr_pulse: assert property (in_ex1 && cmd_q.op == OP_WATCHDOG_RESTART |=>
    wdt_restart && $stable(status_register_q) ##1 !wdt_restart)
    else $error("watchdog restart pulse wrong");

endmodule

// file: dv/mib_mem_model.sv
// Far-side model: data memory, program memory and I/O space.
// Assumes one-cycle strobes, and program writes held until ready.
`timescale 1ns/1ps
module mib_mem_model
  import mib_pkg::*;
#(
  parameter int PW_WAIT = 4
) (
  // Clock
  input wire logic pclk,
  // Data memory
  input wire mib_dmem_s dmem,
  output logic [7:0] dmem_rdata,
  // Program memory
  input wire mib_pmem_s pmem,
  output logic [7:0] pmem_rdata,
  output logic pmem_ready,
  // I/O space
  input wire mib_io_s io
);
  logic [7:0] dm [0:65535];
  logic [7:0] iom [0:63];
  logic [15:0] pw_addr;
  logic [15:0] pw_data;
  int pw_cnt = 0;

  // Known I/O contents so untouched bits can be checked
  initial begin
    pmem_rdata = 8'h00;
    pmem_ready = 1'b0;
    for (int i = 0; i < 64; i++) iom[i] = 8'h5A;
  end

  // Read is combinational; an idle bus shows inverted data, never a stale match
  assign dmem_rdata = dmem.req ? dm[dmem.addr] : ~dm[dmem.addr];

  // Writes land at the strobe edge
  always @(posedge pclk) begin
    if (dmem.req && dmem.we) dm[dmem.addr] <= dmem.wdata;
    if (io.req) iom[io.addr] <= (iom[io.addr] & ~io.mask) | (io.wdata & io.mask);
  end

  // Program read answers one cycle late; the line toggles otherwise
  always @(posedge pclk) begin
    if (pmem.req && !pmem.we) pmem_rdata <= pmem.addr[7:0] ^ 8'hA5;
    else pmem_rdata <= ~pmem_rdata;
  end

  // Slow program write: ready only after PW_WAIT plus one held cycles
  always @(posedge pclk) begin
    if (pmem_ready) begin
      pmem_ready <= 1'b0;
      pw_cnt <= 0;
    end else if (pmem.req && pmem.we) begin
      pw_cnt <= pw_cnt + 1;
      if (pw_cnt == PW_WAIT) begin
        pmem_ready <= 1'b1;
        pw_addr <= pmem.addr;
        pw_data <= pmem.wdata;
      end
    end
  end
endmodule

// file: dv/testbench.sv
// Self-checking bench for the execution unit, one task per scenario.
// Assumes the package register map and the memory model beside it.
`timescale 1ns/1ps
module testbench
  import mib_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, debug_resume, er;
  logic [APB_AW-1:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, pmem_ready, sleep_enter, wdt_restart, debug_break, global_irq_en;
  logic [2:0] sleep_mode;
  logic [7:0] dmem_rdata, pmem_rdata, c;
  mib_dmem_s dmem;
  mib_pmem_s pmem;
  mib_io_s io;
  int n_errors = 0;
  int n_tests = 0;
  int n_slp = 0;
  int n_wdr = 0;
  int n_brk = 0;

  mib_exec_unit mib_exec_unit_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .dmem(dmem), .dmem_rdata(dmem_rdata), .pmem(pmem),
    .pmem_rdata(pmem_rdata), .pmem_ready(pmem_ready), .io(io), .sleep_enter(sleep_enter),
    .sleep_mode(sleep_mode), .wdt_restart(wdt_restart), .debug_break(debug_break),
    .global_irq_en(global_irq_en), .debug_resume(debug_resume));
  mib_mem_model mib_mem_model_i (.pclk(pclk), .dmem(dmem), .dmem_rdata(dmem_rdata),
    .pmem(pmem), .pmem_rdata(pmem_rdata), .pmem_ready(pmem_ready), .io(io));

  // Clock at 100 MHz
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // Count control pulses; a stuck strobe shows up as extra counts
  always @(posedge pclk) begin
    n_slp <= n_slp + int'(sleep_enter === 1'b1);
    n_wdr <= n_wdr + int'(wdt_restart === 1'b1);
    n_brk <= n_brk + int'(debug_break === 1'b1);
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One APB transfer; pready is sampled at each rising edge of the access phase
  task automatic apb(input logic w, input logic [APB_AW-1:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Values read right after the edge are the ones the master sampled there
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [APB_AW-1:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdc(input logic [APB_AW-1:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  function automatic logic [APB_AW-1:0] ga(input int n);
    return OFF_GPR_BASE + APB_AW'(4 * n);
  endfunction

  // Poll busy until it falls, the watchdog ends a hang; then fetch the cycle count
  task automatic wait_idle();
    do apb(1'b0, OFF_STATUS, 32'h0); while (rd[ST_BUSY] !== 1'b0);
    apb(1'b0, OFF_CYCLES, 32'h0);
    c = rd[7:0];
  endtask

  task automatic runc(input mib_op_e op, input logic [4:0] r, input logic [2:0] b,
    input logic [5:0] s, input int cyc);
    wr(OFF_CMD, {12'h000, s, b, r, op});
    wait_idle();
    if (cyc > 0) chk(c, cyc);
  endtask

  task automatic t_store();
    rdc(OFF_STATUS_REGISTER, 32'h0);
    wr(ga(30), 32'h10);
    wr(ga(31), 32'h01);
    wr(ga(5), 32'h3C);
    runc(OP_ST_Z_INC, 5'd5, 3'd0, 6'd0, 2);
    chk(mib_mem_model_i.dm[16'h0110], 8'h3C);
    rdc(ga(30), 32'h11);
    wr(ga(5), 32'h77);
    runc(OP_ST_Z_DEC, 5'd5, 3'd0, 6'd0, 2);
    chk(mib_mem_model_i.dm[16'h0110], 8'h77);
    rdc(ga(30), 32'h10);
    runc(OP_ST_Z_DISP, 5'd5, 3'd0, 6'h3F, 2);
    chk(mib_mem_model_i.dm[16'h014F], 8'h77);
    rdc(ga(30), 32'h10);
    wr(OFF_KWORD, 32'h0234);
    runc(OP_STORE_DIRECT_DATA, 5'd5, 3'd0, 6'd0, 2);
    chk(mib_mem_model_i.dm[16'h0234], 8'h77);
    rdc(OFF_STATUS_REGISTER, 32'h0);
  endtask

  task automatic t_prog();
    wr(ga(30), 32'h42);
    wr(ga(31), 32'h00);
    runc(OP_LOAD_PROGRAM_MEMORY_R0, 5'd0, 3'd0, 6'd0, 3);
    rdc(ga(0), 32'hE7);
    wr(ga(30), 32'hFF);
    runc(OP_LOAD_PROGRAM_MEMORY_INC, 5'd7, 3'd0, 6'd0, 3);
    rdc(ga(7), 32'h5A);
    rdc(ga(31), 32'h01);
    runc(OP_LOAD_PROGRAM_MEMORY, 5'd8, 3'd0, 6'd0, 3);
    rdc(ga(8), 32'hA5);
    rdc(ga(30), 32'h00);
    wr(ga(0), 32'hEF);
    wr(ga(1), 32'hBE);
    runc(OP_STORE_PROGRAM_MEMORY, 5'd0, 3'd0, 6'd0, 0);
    chk(mib_mem_model_i.pw_addr, 32'h0100);
    chk(mib_mem_model_i.pw_data, 32'hBEEF);
  endtask

  task automatic t_stack_io();
    rdc(OFF_SP, 32'h00FF);
    runc(OP_PUSH, 5'd5, 3'd0, 6'd0, 2);
    chk(mib_mem_model_i.dm[16'h00FF], 8'h77);
    rdc(OFF_SP, 32'h00FE);
    runc(OP_POP, 5'd9, 3'd0, 6'd0, 2);
    rdc(ga(9), 32'h77);
    rdc(OFF_SP, 32'h00FF);
    runc(OP_SET_IO_BIT, 5'd0, 3'd7, 6'd3, 2);
    chk(mib_mem_model_i.iom[3], 8'hDA);
    runc(OP_CLEAR_IO_BIT, 5'd0, 3'd1, 6'd3, 2);
    chk(mib_mem_model_i.iom[3], 8'hD8);
    rdc(OFF_STATUS_REGISTER, 32'h0);
  endtask

  // Expected shift result and flags, packed as result, V, N, Z, C
  function automatic logic [11:0] shx(input mib_op_e op, input logic [7:0] a, input logic ci);
    logic [7:0] r;
    logic co;
    case (op)
      OP_LOGICAL_SHIFT_UP: {co, r} = {a, 1'b0};
      OP_LOGICAL_SHIFT_DOWN: {r, co} = {1'b0, a};
      OP_ROTATE_UP_THROUGH_CARRY: {co, r} = {a, ci};
      OP_ROTATE_DOWN_THROUGH_CARRY: {r, co} = {ci, a};
      default: {r, co} = {a[7], a};
    endcase
    return {r, r[7] ^ co, r[7], r == 8'h00, co};
  endfunction

  task automatic t_shift();
    logic [7:0] vals [4] = '{8'h81, 8'h80, 8'h01, 8'h00};
    logic [11:0] e;
    mib_op_e op;
    for (int k = 0; k < 5; k++) begin
      for (int j = 0; j < 8; j++) begin
        op = mib_op_e'(OP_LOGICAL_SHIFT_UP + k);
        e = shx(op, vals[j / 2], j[0]);
        wr(ga(12), {24'h0, vals[j / 2]});
        wr(OFF_STATUS_REGISTER, {24'h0, 7'h18, j[0]});
        runc(op, 5'd12, 3'd0, 6'd0, 1);
        rdc(ga(12), {24'h0, e[11:4]});
        rdc(OFF_STATUS_REGISTER, {24'h0, 4'h3, e[3:0]});
      end
    end
  endtask

  task automatic t_bit_flag();
    wr(OFF_STATUS_REGISTER, 32'h0);
    runc(OP_BIT_TO_TRANSFER_FLAG, 5'd5, 3'd2, 6'd0, 1);
    rdc(OFF_STATUS_REGISTER, 32'h40);
    runc(OP_TRANSFER_FLAG_TO_BIT, 5'd9, 3'd3, 6'd0, 1);
    rdc(ga(9), 32'h7F);
    rdc(OFF_STATUS_REGISTER, 32'h40);
    runc(OP_BIT_TO_TRANSFER_FLAG, 5'd5, 3'd3, 6'd0, 1);
    rdc(OFF_STATUS_REGISTER, 32'h0);
    for (int s = 0; s < 8; s++) begin
      wr(OFF_STATUS_REGISTER, 32'h0);
      runc(OP_FLAG_SET, 5'd0, 3'(s), 6'd0, 1);
      rdc(OFF_STATUS_REGISTER, 32'h1 << s);
      wr(OFF_STATUS_REGISTER, 32'hFF);
      runc(OP_FLAG_CLEAR, 5'd0, 3'(s), 6'd0, 1);
      rdc(OFF_STATUS_REGISTER, 32'hFF ^ (32'h1 << s));
    end
    wr(OFF_STATUS_REGISTER, 32'h0);
    runc(OP_GLOBAL_IRQ_ON, 5'd0, 3'd0, 6'd0, 1);
    chk(global_irq_en, 1'b1);
    rdc(OFF_STATUS_REGISTER, 32'h80);
    runc(OP_GLOBAL_IRQ_OFF, 5'd0, 3'd0, 6'd0, 1);
    chk(global_irq_en, 1'b0);
  endtask

  task automatic t_ctrl();
    wr(OFF_SLEEPCFG, 32'h5);
    wr(OFF_STATUS_REGISTER, 32'h5A);
    runc(OP_SLEEP, 5'd0, 3'd0, 6'd0, 1);
    chk(sleep_mode, 3'h5);
    chk(n_slp, 1);
    runc(OP_WATCHDOG_RESTART, 5'd0, 3'd0, 6'd0, 1);
    chk(n_wdr, 1);
    runc(OP_NOP, 5'd5, 3'd0, 6'd0, 1);
    rdc(ga(5), 32'h77);
    wr(OFF_CMD, {26'h0, OP_BREAK});
    apb(1'b1, OFF_CMD, {26'h0, OP_NOP});
    chk(er, 1'b1);
    apb(1'b0, 12'h020, 32'h0);
    chk(er, 1'b1);
    apb(1'b0, OFF_STATUS, 32'h0);
    chk(rd[ST_HALT], 1'b1);
    chk(n_brk, 1);
    debug_resume <= 1'b1;
    wait_idle();
    debug_resume <= 1'b0;
    // Op code beyond the table is refused and must not start
    apb(1'b1, OFF_CMD, 32'h0000_003F);
    chk(er, 1'b1);
    rdc(OFF_STATUS_REGISTER, 32'h5A);
  endtask

  task automatic test_done();
    $display("errors %0d, comparisons %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Main sequence after a five-cycle reset
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    debug_resume = 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_store();
    t_prog();
    t_stack_io();
    t_shift();
    t_bit_flag();
    t_ctrl();
    test_done();
  end

  // Watchdog well beyond the expected run of some 1900 cycles
  initial begin
    #600000;
    n_errors++;
    test_done();
  end
endmodule
